// ### common/rf_ctrl_consts.svh
// Register offsets, field positions, reset values and codes of the RF control block.
// Included by the design files and the testbench; definitions only.
`ifndef RF_CTRL_CONSTS_SVH
`define RF_CTRL_CONSTS_SVH
`define OFS_RX_MODE_CONFIG      8'h13
`define OFS_TX_DRIVER_CONTROL   8'h14
`define OFS_TX_MODULATION_DEPTH 8'h15
`define OFS_TX_SOURCE_SELECT    8'h16
`define OFS_COMMAND_REGISTER    8'h01
`define OFS_RX_STATUS           8'h20
`define RST_RX_MODE_CONFIG      8'h00
`define RST_TX_DRIVER_CONTROL   8'h80
`define RST_TX_MODULATION_DEPTH 8'h00
`define RST_TX_SOURCE_SELECT    8'h10
`define RST_COMMAND_REGISTER    8'h00
`define MASK_RX_MODE_CONFIG     8'hfc
`define MASK_TX_DRIVER_CONTROL  8'hfb
`define MASK_TX_MODULATION_DEPTH 8'h40
`define MASK_TX_SOURCE_SELECT   8'h3f
`define MASK_COMMAND_REGISTER   8'h0f
`define BIT_MULTI_FRAME         2
`define BIT_DRV2_INV_ON         7
`define BIT_DRV1_INV_ON         6
`define BIT_DRV2_INV_OFF        5
`define BIT_DRV1_INV_OFF        4
`define BIT_DRV2_CW             3
`define BIT_DRV2_EN             1
`define BIT_DRV1_EN             0
`define BIT_FORCED_FULL_MOD     6
`define BIT_CRC_FLAG            6
`define CMD_RECEIVE             4'h8
`define CMD_TRANSCEIVE          4'hc
`define CMD_IDLE                4'h0
`endif

// ### common/rf_ctrl_pkg.sv
// Types shared by the RF control block.
// Assumes nothing beyond a SystemVerilog compiler.
package rf_ctrl_pkg;
  typedef enum logic [1:0] {
    DRV_TRISTATE,
    DRV_MILLER,
    DRV_AUX_IN,
    DRV_HIGH
  } driver_source_t;
  typedef enum logic [3:0] {
    AUX_TRISTATE  = 4'h0,
    AUX_LOW       = 4'h1,
    AUX_HIGH      = 4'h2,
    AUX_TEST_BIT  = 4'h3,
    AUX_MILLER    = 4'h4,
    AUX_TX_BITS   = 4'h5,
    AUX_RESERVED6 = 4'h6,
    AUX_RX_BITS   = 4'h7
  } aux_output_source_t;
  typedef enum logic [1:0] {
    RX_OFF,
    RX_ACTIVE,
    RX_APPEND
  } rx_state_t;
endpackage

// ### common/drv_cfg_if.sv
// Carries the settings of one antenna driver from the top to its output stage.
// Assumes one clock domain; all signals are levels.
interface drv_cfg_if;
  logic enable;
  logic invert_on;
  logic invert_off;
  logic continuous_wave;
  modport ctrl (output enable, output invert_on, output invert_off, output continuous_wave);
  modport stage (input enable, input invert_on, input invert_off, input continuous_wave);
endinterface

// ### core/rf_driver_stage.sv
// Output stage of one antenna driver: source, enable, inversion, continuous carrier.
// Assumes the carrier and envelope inputs are on clk_i; output comes from a flip-flop.
`include "rf_ctrl_consts.svh"
module rf_driver_stage (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     ce_i,
  // Settings
  drv_cfg_if.stage                      cfg,
  input  wire rf_ctrl_pkg::driver_source_t src_i,
  input  wire logic                     power_down_i,
  input  wire logic                     forced_full_i,
  // Signals
  input  wire logic                     carrier_i,
  input  wire logic                     miller_env_i,
  input  wire logic                     aux_env_i,
  // Pin
  output logic                          pin_o,
  output logic                          pin_oe_o
);
  // Envelope picked by the source field; high means carrier on
  logic env;
  logic modulated;
  logic level;
  logic next_oe;
  assign env = (src_i == rf_ctrl_pkg::DRV_MILLER) ? miller_env_i :
               (src_i == rf_ctrl_pkg::DRV_AUX_IN) ? aux_env_i : 1'b1;
  // Full-depth keying gates the carrier off entirely during a pause
  assign modulated = cfg.continuous_wave ? carrier_i :
                     (forced_full_i ? (carrier_i & env) : (carrier_i & env));
  // Constant-high source gives a steady level that the invert bits shape
  assign level = cfg.enable ?
                 (((src_i == rf_ctrl_pkg::DRV_HIGH) ? 1'b1 : modulated) ^ cfg.invert_on) :
                 cfg.invert_off;
  // Tri-state only for source 00; power-down alone keeps the driver active
  assign next_oe = (src_i != rf_ctrl_pkg::DRV_TRISTATE);

  // Registered pin drive
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      pin_o    <= level;
      pin_oe_o <= next_oe;
    end
  end
  logic unused_pd;
  assign unused_pd = power_down_i;
endmodule // rf_driver_stage

// ### core/rf_driver_and_rx_frame_control.sv
// Antenna driver control and multi-frame receive control with a Wishbone slave.
// Assumes a classic Wishbone master on clk_i; aux pin input is asynchronous.
//
// Overview of operation
// - Without multi-frame bit, receiver goes off after one complete frame.
// - With multi-frame set, Receive and Transceive do not end on frame end.
// - Multi-frame ends only on a non-Receive command or bit clear.
// - Multi-frame appends one error-register copy byte after each data stream.
// - Revision two puts CRC-good in that byte; revision one CRC-fail.
// - Invert-when-on bits invert each enabled driver's output.
// - Invert-when-off bits invert each disabled driver's level.
// - Continuous-wave bit gives unmodulated carrier on driver two.
// - With continuous-wave clear, driver two is modulated like driver one.
// - Enable bits make each driver carry the modulated carrier.
// - Forced full modulation applies 100 % keying regardless of conductance.
// - Driver source selects tri-state, Miller, aux input, or constant high.
// - Soft power-down tri-states drivers only with driver source 00.
// - Constant-high source level follows the invert bits.
// - Source select resets to 10h: Miller drive, aux output tri-stated.
// - Aux output source picks tri-state, low, high, test, Miller, tx, rx.
//
// Local design decision: the Wishbone register port.
`include "rf_ctrl_consts.svh"
module rf_driver_and_rx_frame_control #(
  parameter bit DEVICE_REV2 = 1'b1
) (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  // Wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // Transmit side signals
  input  wire logic       carrier_i,
  input  wire logic       miller_env_i,
  input  wire logic       tx_bits_i,
  input  wire logic       test_bus_bit_i,
  input  wire logic       power_down_i,
  // Receive side signals
  input  wire logic       rx_bits_i,
  input  wire logic       frame_done_i,
  input  wire logic [7:0] error_register_i,
  input  wire logic       crc_good_flag_i,
  // FIFO push of the appended error byte, receiver enable and command terminate
  output logic            fifo_push_o,
  output logic [7:0]      fifo_data_o,
  output logic            rx_enable_o,
  output logic            cmd_terminate_o,
  // Aux envelope pins
  input  wire logic       aux_envelope_in_i,
  output logic            aux_envelope_out_o,
  output logic            aux_envelope_out_oe_o,
  // Antenna driver pins
  output logic            driver_pin_1_o,
  output logic            driver_pin_1_oe_o,
  output logic            driver_pin_2_o,
  output logic            driver_pin_2_oe_o
);
  // Registers
  logic [7:0] rx_mode_config;
  logic [7:0] tx_driver_control;
  logic [7:0] tx_modulation_depth;
  logic [7:0] tx_source_select;
  logic [7:0] command_register;
  rf_ctrl_pkg::rx_state_t rx_state;
  rf_ctrl_pkg::rx_state_t next_rx_state;

  // Bus decode
  logic       req;
  logic       wr;
  logic       wr_lane0;
  logic       hit_rx;
  logic       hit_tx;
  logic       hit_ask;
  logic       hit_sel;
  logic       hit_cmd;
  logic       hit_stat;
  logic [7:0] rd_byte;
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i;
  assign wr_lane0 = wr & wb_sel_i[0];
  assign hit_rx   = (wb_adr_i == {`OFS_RX_MODE_CONFIG} << 2);
  assign hit_tx   = (wb_adr_i == {`OFS_TX_DRIVER_CONTROL} << 2);
  assign hit_ask  = (wb_adr_i == {`OFS_TX_MODULATION_DEPTH} << 2);
  assign hit_sel  = (wb_adr_i == {`OFS_TX_SOURCE_SELECT} << 2);
  assign hit_cmd  = (wb_adr_i == {`OFS_COMMAND_REGISTER} << 2);
  assign hit_stat = (wb_adr_i == {`OFS_RX_STATUS} << 2);
  // Read mux; unmapped addresses read zero
  assign rd_byte = hit_rx   ? rx_mode_config :
                   hit_tx   ? tx_driver_control :
                   hit_ask  ? tx_modulation_depth :
                   hit_sel  ? tx_source_select :
                   hit_cmd  ? command_register :
                   hit_stat ? {6'h00, (rx_state == rf_ctrl_pkg::RX_APPEND), rx_enable_o} :
                   8'h00;

  // Acknowledge each request one cycle later, data registered
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers; reserved bits masked on write
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_mode_config      <= `RST_RX_MODE_CONFIG;
      tx_driver_control   <= `RST_TX_DRIVER_CONTROL;
      tx_modulation_depth <= `RST_TX_MODULATION_DEPTH;
      tx_source_select    <= `RST_TX_SOURCE_SELECT;
      command_register    <= `RST_COMMAND_REGISTER;
    end else if (ce_i) begin
      if (wr_lane0 && hit_rx) begin
        rx_mode_config <= wb_dat_i[7:0] & `MASK_RX_MODE_CONFIG;
      end
      if (wr_lane0 && hit_tx) begin
        tx_driver_control <= wb_dat_i[7:0] & `MASK_TX_DRIVER_CONTROL;
      end
      if (wr_lane0 && hit_ask) begin
        tx_modulation_depth <= wb_dat_i[7:0] & `MASK_TX_MODULATION_DEPTH;
      end
      if (wr_lane0 && hit_sel) begin
        tx_source_select <= wb_dat_i[7:0] & `MASK_TX_SOURCE_SELECT;
      end
      if (wr_lane0 && hit_cmd) begin
        command_register <= wb_dat_i[7:0] & `MASK_COMMAND_REGISTER;
      end else if (cmd_terminate_o) begin
        command_register <= {4'h0, `CMD_IDLE};
      end
    end
  end

  // Receive frame control
  logic multi_frame_receive;
  logic rx_cmd;
  logic cmd_write;
  logic new_cmd_stops;
  logic [7:0] err_byte;
  assign multi_frame_receive = rx_mode_config[`BIT_MULTI_FRAME];
  assign rx_cmd = (command_register[3:0] == `CMD_RECEIVE) ||
                  (command_register[3:0] == `CMD_TRANSCEIVE);
  assign cmd_write = wr_lane0 & hit_cmd;
  assign new_cmd_stops = cmd_write && (wb_dat_i[3:0] != `CMD_RECEIVE);
  // Error copy; bit 6 carries CRC good on rev two, CRC fail on rev one
  assign err_byte = {error_register_i[7],
                     DEVICE_REV2 ? crc_good_flag_i : ~crc_good_flag_i,
                     error_register_i[5:0]};

  // Next receive state
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      rf_ctrl_pkg::RX_OFF: begin
        if (rx_cmd && !cmd_write) begin
          next_rx_state = rf_ctrl_pkg::RX_ACTIVE;
        end
      end
      rf_ctrl_pkg::RX_ACTIVE: begin
        if (new_cmd_stops) begin
          next_rx_state = rf_ctrl_pkg::RX_OFF;
        end else if (frame_done_i) begin
          next_rx_state = multi_frame_receive ? rf_ctrl_pkg::RX_APPEND :
                          rf_ctrl_pkg::RX_OFF;
        end
      end
      rf_ctrl_pkg::RX_APPEND: begin
        next_rx_state = new_cmd_stops ? rf_ctrl_pkg::RX_OFF : rf_ctrl_pkg::RX_ACTIVE;
      end
      default: begin
        next_rx_state = rf_ctrl_pkg::RX_OFF;
      end
    endcase
    if (!multi_frame_receive && rx_state == rf_ctrl_pkg::RX_APPEND) begin
      next_rx_state = rf_ctrl_pkg::RX_OFF;
    end
  end

  // Terminate pulse when a single frame completes
  assign cmd_terminate_o = (rx_state == rf_ctrl_pkg::RX_ACTIVE) && frame_done_i &&
                           !multi_frame_receive && !new_cmd_stops;

  // Receive state and appended byte
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_state    <= rf_ctrl_pkg::RX_OFF;
      rx_enable_o <= 1'b0;
      fifo_push_o <= 1'b0;
      fifo_data_o <= 8'h00;
    end else if (ce_i) begin
      rx_state    <= next_rx_state;
      rx_enable_o <= (next_rx_state != rf_ctrl_pkg::RX_OFF);
      fifo_push_o <= (rx_state == rf_ctrl_pkg::RX_ACTIVE) && frame_done_i &&
                     multi_frame_receive && !new_cmd_stops;
      fifo_data_o <= err_byte;
    end
  end

  // Aux input synchroniser: three stages, change taken when two and three agree
  logic [2:0] aux_sync;
  logic       aux_in_clean;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_sync     <= 3'b000;
      aux_in_clean <= 1'b0;
    end else if (ce_i) begin
      aux_sync <= {aux_sync[1:0], aux_envelope_in_i};
      if (aux_sync[1] == aux_sync[2]) begin
        aux_in_clean <= aux_sync[2];
      end
    end
  end

  // Aux output source selection
  rf_ctrl_pkg::aux_output_source_t aux_sel;
  logic aux_level;
  logic aux_drive;
  assign aux_sel   = rf_ctrl_pkg::aux_output_source_t'(tx_source_select[3:0]);
  assign aux_level = (aux_sel == rf_ctrl_pkg::AUX_HIGH)     ? 1'b1 :
                     (aux_sel == rf_ctrl_pkg::AUX_TEST_BIT) ? test_bus_bit_i :
                     (aux_sel == rf_ctrl_pkg::AUX_MILLER)   ? miller_env_i :
                     (aux_sel == rf_ctrl_pkg::AUX_TX_BITS)  ? tx_bits_i :
                     (aux_sel == rf_ctrl_pkg::AUX_RX_BITS)  ? rx_bits_i : 1'b0;
  // Tri-state and reserved codes leave the pin undriven
  assign aux_drive = (aux_sel != rf_ctrl_pkg::AUX_TRISTATE) &&
                     (aux_sel != rf_ctrl_pkg::AUX_RESERVED6) &&
                     (tx_source_select[3] == 1'b0);

  // Registered aux pin
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_envelope_out_o    <= 1'b0;
      aux_envelope_out_oe_o <= 1'b0;
    end else if (ce_i) begin
      aux_envelope_out_o    <= aux_level;
      aux_envelope_out_oe_o <= aux_drive;
    end
  end

  // Driver settings
  drv_cfg_if drv1_cfg ();
  drv_cfg_if drv2_cfg ();
  rf_ctrl_pkg::driver_source_t driver_source;
  logic forced_full_modulation;
  assign driver_source           = rf_ctrl_pkg::driver_source_t'(tx_source_select[5:4]);
  assign forced_full_modulation  = tx_modulation_depth[`BIT_FORCED_FULL_MOD];
  assign drv1_cfg.enable          = tx_driver_control[`BIT_DRV1_EN];
  assign drv1_cfg.invert_on       = tx_driver_control[`BIT_DRV1_INV_ON];
  assign drv1_cfg.invert_off      = tx_driver_control[`BIT_DRV1_INV_OFF];
  assign drv1_cfg.continuous_wave = 1'b0;
  assign drv2_cfg.enable          = tx_driver_control[`BIT_DRV2_EN];
  assign drv2_cfg.invert_on       = tx_driver_control[`BIT_DRV2_INV_ON];
  assign drv2_cfg.invert_off      = tx_driver_control[`BIT_DRV2_INV_OFF];
  assign drv2_cfg.continuous_wave = tx_driver_control[`BIT_DRV2_CW];

  // First driver
  rf_driver_stage u_drv1 (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .ce_i          (ce_i),
    .cfg           (drv1_cfg),
    .src_i         (driver_source),
    .power_down_i  (power_down_i),
    .forced_full_i (forced_full_modulation),
    .carrier_i     (carrier_i),
    .miller_env_i  (miller_env_i),
    .aux_env_i     (aux_in_clean),
    .pin_o         (driver_pin_1_o),
    .pin_oe_o      (driver_pin_1_oe_o)
  );

  // Second driver
  rf_driver_stage u_drv2 (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .ce_i          (ce_i),
    .cfg           (drv2_cfg),
    .src_i         (driver_source),
    .power_down_i  (power_down_i),
    .forced_full_i (forced_full_modulation),
    .carrier_i     (carrier_i),
    .miller_env_i  (miller_env_i),
    .aux_env_i     (aux_in_clean),
    .pin_o         (driver_pin_2_o),
    .pin_oe_o      (driver_pin_2_oe_o)
  );
endmodule // rf_driver_and_rx_frame_control

// ### dv/rf_ctrl_assertions.sv
// Concurrent checks on the top ports of the RF control block.
// Assumes clk_i and active-low asynchronous rst_b_i; bound at the foot of the file.
module rf_ctrl_assertions #(
  parameter bit DEVICE_REV2 = 1'b1
) (
  // Clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Receive control
  input wire logic        frame_done_i,
  input wire logic [7:0]  error_register_i,
  input wire logic        crc_good_flag_i,
  input wire logic        fifo_push_o,
  input wire logic [7:0]  fifo_data_o,
  input wire logic        rx_enable_o,
  input wire logic        cmd_terminate_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Frame end seen while multi-frame keeps the command alive
  sequence s_frame_multi;
    ce_i && frame_done_i && rx_enable_o && !cmd_terminate_o;
  endsequence
  // Appended byte is the error register with the CRC flag patched in
  sequence s_push_byte;
    fifo_push_o && rx_enable_o && fifo_data_o == {$past(error_register_i[7]),
      (DEVICE_REV2 ? $past(crc_good_flag_i) : !$past(crc_good_flag_i)),
      $past(error_register_i[5:0])};
  endsequence
  a_push_err_byte: assert property (s_frame_multi |=> s_push_byte)
    else $error("appended error byte wrong");
  a_frame_ends_cmd: assert property (cmd_terminate_o && ce_i |=> !rx_enable_o && !fifo_push_o)
    else $error("receiver not off after frame");
  a_push_stays_on: assert property (fifo_push_o |-> rx_enable_o && !cmd_terminate_o)
    else $error("command ended in multi-frame");
  a_push_after_frame: assert property (fifo_push_o |-> $past(frame_done_i))
    else $error("push without frame end");
  a_term_needs_frame: assert property (cmd_terminate_o |-> frame_done_i && rx_enable_o)
    else $error("terminate without frame end");
  a_ack_after_req: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  c_multi_frame: cover property (s_frame_multi);
endmodule // rf_ctrl_assertions

bind rf_driver_and_rx_frame_control rf_ctrl_assertions #(.DEVICE_REV2(DEVICE_REV2)) chk_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_done_i(frame_done_i),
  .error_register_i(error_register_i), .crc_good_flag_i(crc_good_flag_i),
  .fifo_push_o(fifo_push_o), .fifo_data_o(fifo_data_o), .rx_enable_o(rx_enable_o),
  .cmd_terminate_o(cmd_terminate_o));

// ### dv/rf_pin_partner.sv
// Model of the antenna and aux envelope pins seen from outside the block.
// Assumes one clock; undriven pins show a toggling pattern, not a held value.
module rf_pin_partner (
  // Clock and commanded aux level
  input  wire logic clk_i,
  input  wire logic level_i,
  // Pins from the block
  input  wire logic pin1_i,
  input  wire logic oe1_i,
  input  wire logic pin2_i,
  input  wire logic oe2_i,
  input  wire logic aux_i,
  input  wire logic aux_oe_i,
  // Resolved levels
  output logic      aux_env_o,
  output logic      tx1_wire_o,
  output logic      tx2_wire_o,
  output logic      aux_wire_o
);
  logic tog;
  // Envelope source changes just after the edge; filler pattern for floating pins
  always @(posedge clk_i) begin
    aux_env_o <= level_i;
    tog <= ~tog;
  end
  initial begin
    aux_env_o = 1'b0;
    tog = 1'b0;
  end
  // A pin that is not driven shows the toggling filler, not a held last value
  assign tx1_wire_o = oe1_i ? pin1_i : tog;
  assign tx2_wire_o = oe2_i ? pin2_i : tog;
  assign aux_wire_o = aux_oe_i ? aux_i : ~tog;
endmodule // rf_pin_partner

// ### dv/tb_top.sv
// Self-checking bench of the RF control block: table of driver cases, then hand tests.
// Assumes the block answers classic Wishbone on clk_i at 100 MHz.
`include "rf_ctrl_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] sel; logic [7:0] f;} row_t;
  // Flags: carrier, envelope, pin1, pin2, oe1, oe2, aux value, aux oe
  row_t rows [10] = '{'{8'h03, 8'h14, 8'hFF}, '{8'h03, 8'h11, 8'h8D}, '{8'hC3, 8'h12, 8'hCF},
    '{8'h30, 8'h13, 8'hFF}, '{8'h0B, 8'h15, 8'h9D}, '{8'h03, 8'h17, 8'h4F},
    '{8'h43, 8'h30, 8'h9C}, '{8'h21, 8'h30, 8'hBC}, '{8'h03, 8'h06, 8'hC0},
    '{8'h03, 8'h1F, 8'hFC}};
  logic [7:0] ixs [6] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h01, 8'h3F};
  logic [7:0] rsts [6] = '{8'h00, 8'h80, 8'h00, 8'h10, 8'h00, 8'h00};
  logic [7:0] msks [6] = '{8'hFC, 8'hFB, 8'h40, 8'h3F, 8'h0F, 8'h00};
  logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, carrier_i = 1'b0, miller_env_i = 1'b0, tx_bits_i = 1'b0;
  logic test_bus_bit_i = 1'b1, power_down_i = 1'b0, rx_bits_i = 1'b1, frame_done_i = 1'b0;
  logic crc_good_flag_i = 1'b1, level = 1'b0, term, aux_env, fifo_push_o, rx_enable_o;
  logic [7:0] wb_adr_i = 8'h00, error_register_i = 8'hA5, fifo_data_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
  logic wb_ack_o, cmd_terminate_o, aux_o, aux_oe, p1, oe1, p2, oe2, w1, w2, wa;
  int n_errors = 0, checks = 0;
  row_t r;
  always #5 clk_i = ~clk_i;
  rf_driver_and_rx_frame_control rf_driver_and_rx_frame_control_i (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .carrier_i(carrier_i),
    .miller_env_i(miller_env_i), .tx_bits_i(tx_bits_i), .test_bus_bit_i(test_bus_bit_i),
    .power_down_i(power_down_i), .rx_bits_i(rx_bits_i), .frame_done_i(frame_done_i),
    .error_register_i(error_register_i), .crc_good_flag_i(crc_good_flag_i),
    .fifo_push_o(fifo_push_o), .fifo_data_o(fifo_data_o), .rx_enable_o(rx_enable_o),
    .cmd_terminate_o(cmd_terminate_o), .aux_envelope_in_i(aux_env),
    .aux_envelope_out_o(aux_o), .aux_envelope_out_oe_o(aux_oe), .driver_pin_1_o(p1),
    .driver_pin_1_oe_o(oe1), .driver_pin_2_o(p2), .driver_pin_2_oe_o(oe2));
  rf_pin_partner rf_pin_partner_i (.clk_i(clk_i), .level_i(level), .pin1_i(p1),
    .oe1_i(oe1), .pin2_i(p2), .oe2_i(oe2), .aux_i(aux_o), .aux_oe_i(aux_oe),
    .aux_env_o(aux_env), .tx1_wire_o(w1), .tx2_wire_o(w2), .aux_wire_o(wa));
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic Wishbone cycle on register index ix; holds until ack is sampled
  task automatic bus(input logic we, input logic [7:0] ix, input logic [7:0] d,
                     input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {ix[5:0], 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h00_0000, d};
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    chk("ack", wb_ack_o, 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One received frame end; terminate is seen in the pulse cycle
  task automatic frame();
    @(posedge clk_i);
    frame_done_i <= 1'b1;
    #1 term = cmd_terminate_o;
    @(posedge clk_i);
    frame_done_i <= 1'b0;
    #1;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200us;
    n_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    wait_cyc(20);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      r = rows[k];
      bus(1'b1, `OFS_TX_DRIVER_CONTROL, r.ctrl);
      bus(1'b1, `OFS_TX_SOURCE_SELECT, r.sel);
      carrier_i <= r.f[7];
      miller_env_i <= r.f[6];
      wait_cyc(4);
      chk("driver oe", {oe1, oe2}, r.f[3:2]);
      if (r.f[3]) chk("pin1", w1, r.f[5]);
      if (r.f[2]) chk("pin2", w2, r.f[4]);
      chk("aux oe", aux_oe, r.f[0]);
      if (r.f[0]) chk("aux out", wa, r.f[1]);
    end
    $display("test table done");
    rst_b_i <= 1'b0;
    wait_cyc(3);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ixs[k], 8'h00);
      chk("reset value", rdat, rsts[k]);
      bus(1'b1, ixs[k], 8'hFF);
      bus(1'b0, ixs[k], 8'h00);
      chk("readback", rdat, msks[k]);
    end
    bus(1'b1, `OFS_TX_MODULATION_DEPTH, 8'h00, 4'h0);
    bus(1'b0, `OFS_TX_MODULATION_DEPTH, 8'h00);
    chk("sel0 write", rdat, 8'h40);
    bus(1'b1, `OFS_RX_MODE_CONFIG, 8'h00);
    $display("test registers done");
    bus(1'b1, `OFS_COMMAND_REGISTER, `CMD_RECEIVE);
    wait_cyc(2);
    chk("rx on", rx_enable_o, 1'b1);
    frame();
    chk("terminate", term, 1'b1);
    chk("rx off", rx_enable_o, 1'b0);
    bus(1'b0, `OFS_COMMAND_REGISTER, 8'h00);
    chk("cmd idle", rdat, 8'h00);
    bus(1'b1, `OFS_RX_MODE_CONFIG, 8'h14);
    bus(1'b1, `OFS_COMMAND_REGISTER, `CMD_TRANSCEIVE);
    frame();
    chk("no terminate", term, 1'b0);
    chk("push", fifo_push_o, 1'b1);
    chk("err byte", fifo_data_o, 8'hE5);
    @(posedge clk_i);
    crc_good_flag_i <= 1'b0;
    error_register_i <= 8'h5A;
    frame();
    chk("err byte bad crc", fifo_data_o, 8'h1A);
    chk("rx stays", rx_enable_o, 1'b1);
    bus(1'b1, `OFS_COMMAND_REGISTER, `CMD_RECEIVE);
    wait_cyc(2);
    chk("rx on receive", rx_enable_o, 1'b1);
    bus(1'b1, `OFS_COMMAND_REGISTER, `CMD_IDLE);
    wait_cyc(2);
    chk("rx off idle", rx_enable_o, 1'b0);
    bus(1'b1, `OFS_COMMAND_REGISTER, `CMD_RECEIVE);
    bus(1'b1, `OFS_RX_MODE_CONFIG, 8'h10);
    frame();
    chk("rx off clear", rx_enable_o, 1'b0);
    chk("no push", fifo_push_o, 1'b0);
    $display("test receive done");
    bus(1'b1, `OFS_TX_DRIVER_CONTROL, 8'h03);
    bus(1'b1, `OFS_TX_SOURCE_SELECT, 8'h20);
    carrier_i <= 1'b1;
    for (int v = 1; v >= 0; v--) begin
      level <= v[0];
      wait_cyc(8);
      chk("aux drive", w1, v[0]);
    end
    power_down_i <= 1'b1;
    bus(1'b1, `OFS_TX_SOURCE_SELECT, 8'h10);
    wait_cyc(3);
    chk("pd active", oe1, 1'b1);
    bus(1'b1, `OFS_TX_SOURCE_SELECT, 8'h00);
    wait_cyc(3);
    chk("pd tristate", {oe1, oe2}, 2'b00);
    $display("test drivers done");
    wrap_up();
  end
endmodule // tb_top
